// file: rtl/gnss_msg_pkg.sv
// Constants, field layouts and states shared by the binary message framer.
// Assumes one 50 MHz clock domain; nothing here is synthesised on its own.
package gnss_msg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Frame markers and type letters
    localparam logic [7:0]  START_BYTE   = 8'h02; // Start of frame marker
    localparam logic [7:0]  END_BYTE     = 8'h03; // End of frame marker
    localparam logic [7:0]  TYPE_HEALTH  = 8'h53; // Letter S
    localparam logic [7:0]  TYPE_AUG     = 8'h57; // Letter W

    ////////////////////////////////////////////////////////////////////////
    // Payload geometry
    localparam int          FIELD_BYTES  = 24;    // One subframe field
    localparam int          FIELD_BITS   = FIELD_BYTES * 8;
    localparam int          HEALTH_BYTES = 2 * FIELD_BYTES;
    localparam int          HEALTH_BITS  = HEALTH_BYTES * 8;
    localparam int          RECORD_BYTES = 29;    // One GEO record
    localparam int          RECORD_BITS  = RECORD_BYTES * 8;
    localparam int          GEO_DATA_BITS = 212;  // Broadcast data word
    localparam int          MAX_GEO      = 4;
    localparam logic [15:0] HEALTH_LEN   = 16'h0030;
    localparam logic [15:0] PARAM_LEN    = 16'h0001;
    localparam logic [15:0] RECORD_LEN   = 16'h001d;
    localparam logic [5:0]  HEALTH_LAST  = 6'h2f;
    localparam logic [5:0]  RECORD_LAST  = 6'h1c;
    localparam logic [1:0]  ZERO2        = 2'h0;  // Fixed zero fields
    localparam logic        ZERO1        = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0]               prn;         // Satellite PRN
        logic                     crc_bad;     // 1 = CRC check failed
        logic [5:0]               msg_type;    // Broadcast message type
        logic [1:0]               preamble_id; // Preamble byte 1..3
        logic [GEO_DATA_BITS-1:0] data;        // Data word, MSB first
    } geo_record_s;

    typedef struct packed {
        logic [2:0]                  geo_count; // 1..4 records
        geo_record_s [MAX_GEO-1:0]   rec;       // rec[0] sent first
    } aug_msg_s;

    typedef struct packed {
        logic [FIELD_BITS-1:0] sf4;       // Subframe 4 words 3..10
        logic [FIELD_BITS-1:0] sf5;       // Subframe 5 words 3..10
        logic                  sf4_valid; // Sensor declared sf4 valid
        logic                  sf5_valid; // Sensor declared sf5 valid
    } health_msg_s;

    ////////////////////////////////////////////////////////////////////////
    // Framer states, Gray coded along the frame path except ST_END to ST_IDLE, which flips two bits
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_START   = 4'h1,
        ST_TYPE    = 4'h3,
        ST_LEN_HI  = 4'h2,
        ST_LEN_LO  = 4'h6,
        ST_PAYLOAD = 4'h7,
        ST_CK_HI   = 4'h5,
        ST_CK_LO   = 4'h4,
        ST_END     = 4'hc
    } frame_state_e;

endpackage

// file: rtl/frame_checksum.sv
// Running 16-bit additive checksum over the bytes of one frame.
// Assumes the framer clears it once per frame before the first add.
`timescale 1ns/1ps
module frame_checksum (
    // Clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        ce_in,
    // Control and data
    input  wire logic        clear_in,
    input  wire logic        add_in,
    input  wire logic [7:0]  byte_in,
    // Result
    output logic      [15:0] sum_out
);

    logic [15:0] sum;       // Current sum
    logic [15:0] next_sum;  // Sum after this cycle

    ////////////////////////////////////////////////////////////////////////
    // Clear wins over add so a new frame never inherits an old byte
    always_comb begin
        next_sum = sum;
        if (clear_in) begin
            next_sum = 16'h0000;
        end else if (add_in) begin
            next_sum = 16'(sum + {8'h00, byte_in});
        end
    end

    // Register only
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sum <= 16'h0000;
        end else if (ce_in) begin
            sum <= next_sum;
        end
    end

    assign sum_out = sum;

endmodule

// file: rtl/gnss_binary_msg_framer.sv
// Frames the health message and the augmentation data message into a
// byte stream with valid/ready handshake toward the host serial link.
// Assumes requests and data come from logic on the same clock.
//
// Notes on behaviour
// - First health field: subframe 4, valid only
// - Second health field: subframe 5, valid only
// - Parameter high nibble: counter, wraps mod 16
// - Parameter bits 3 and 2 are zero
// - Parameter bits 1..0 encode GEO count
// - Record byte 2 bit 7: CRC bad flag
// - Record byte 2 bit 6 is zero
// - Record byte 2 bits 5..0: message type
// - Record byte 3 bits 7..6: preamble byte
// - Record byte 3 bits 5..4 are zero
// - Record byte 3 bits 3..0: data MSBs
// - Last 26 bytes: remaining 208 data bits
`timescale 1ns/1ps
module gnss_binary_msg_framer (
    // Clock, reset, enable
    input  wire logic                      clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic                      ce_in,
    // Health message request
    input  wire logic                      health_req_in,
    input  wire gnss_msg_pkg::health_msg_s health_in,
    // Augmentation message request
    input  wire logic                      aug_req_in,
    input  wire gnss_msg_pkg::aug_msg_s    aug_in,
    // Byte stream toward the host link
    output logic      [7:0]                byte_out,
    output logic                           byte_valid_out,
    input  wire logic                      byte_ready_in,
    // Status
    output logic                           busy_out,
    output logic                           req_refused_out,
    output logic      [3:0]                msg_counter_out
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // GEO count 1..4 to two-bit code; four wraps to 00
    function automatic logic [1:0] geo_code(input logic [2:0] n);
        return n[1:0];
    endfunction

    // Legal GEO count check, used for acceptance and nothing else
    function automatic logic geo_ok(input logic [2:0] n);
        return (n != 3'h0) && (n <= 3'(gnss_msg_pkg::MAX_GEO));
    endfunction

    // Byte k of one 29-byte GEO record
    function automatic logic [7:0] record_byte(
        input gnss_msg_pkg::geo_record_s r,
        input logic [5:0]                k
    );
        logic [gnss_msg_pkg::RECORD_BITS-1:0] bits;
        bits = {r.prn,
                r.crc_bad,
                gnss_msg_pkg::ZERO1,
                r.msg_type,
                r.preamble_id,
                gnss_msg_pkg::ZERO2,
                r.data};
        // Data LSBs fill the last 26 bytes in order
        return bits[gnss_msg_pkg::RECORD_BITS - 1 - 8 * int'(k) -: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    localparam int HB_W = gnss_msg_pkg::HEALTH_BITS;

    gnss_msg_pkg::frame_state_e state,      next_state;      // Framer
    logic                       is_aug,     next_is_aug;     // Message kind
    logic [5:0]                 off,        next_off;        // Byte index
    logic [1:0]                 rec,        next_rec;        // Record index
    logic                       param_sent, next_param_sent; // Param done
    logic [3:0]                 counter,    next_counter;    // Aug counter
    logic [15:0]                len,        next_len;        // Payload len
    gnss_msg_pkg::health_msg_s  hsnap,      next_hsnap;      // Health copy
    gnss_msg_pkg::aug_msg_s     asnap,      next_asnap;      // Aug copy
    logic [7:0]                 obyte,      next_obyte;      // Output byte
    logic                       ovalid,     next_ovalid;     // Output valid
    logic                       refused,    next_refused;    // Refusal pulse

    logic                       advance;    // Output slot free this cycle
    logic                       sum_clear;  // Start of a new frame
    logic                       sum_add;    // Byte enters the checksum
    logic [15:0]                sum;        // Running checksum
    logic [HB_W-1:0]            hbits;      // Both health fields in order

    assign advance = !ovalid || byte_ready_in;
    assign hbits   = {hsnap.sf4, hsnap.sf5};

    ////////////////////////////////////////////////////////////////////////
    // Checksum over type, length and payload bytes
    frame_checksum u_sum (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .clear_in   (sum_clear),
        .add_in     (sum_add),
        .byte_in    (next_obyte),
        .sum_out    (sum)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: one output byte per free slot
    always_comb begin
        next_state      = state;
        next_is_aug     = is_aug;
        next_off        = off;
        next_rec        = rec;
        next_param_sent = param_sent;
        next_counter    = counter;
        next_len        = len;
        next_hsnap      = hsnap;
        next_asnap      = asnap;
        next_obyte      = obyte;
        next_ovalid     = ovalid && !byte_ready_in;
        next_refused    = 1'b0;
        sum_clear       = 1'b0;
        sum_add         = 1'b0;
        unique case (state)
            gnss_msg_pkg::ST_IDLE: begin
                // Health needs both fields declared valid
                if (health_req_in) begin
                    if (health_in.sf4_valid && health_in.sf5_valid) begin
                        next_hsnap  = health_in;
                        next_is_aug = 1'b0;
                        next_len    = gnss_msg_pkg::HEALTH_LEN;
                        sum_clear   = 1'b1;
                        next_state  = gnss_msg_pkg::ST_START;
                    end else begin
                        next_refused = 1'b1;
                    end
                    // Health has priority; a same-cycle aug request is lost
                    next_refused = next_refused || aug_req_in;
                end else if (aug_req_in) begin
                    if (geo_ok(aug_in.geo_count)) begin
                        next_asnap   = aug_in;
                        next_is_aug  = 1'b1;
                        next_counter = 4'(counter + 4'h1);
                        next_len     = 16'(gnss_msg_pkg::PARAM_LEN +
                                       16'(gnss_msg_pkg::RECORD_LEN *
                                           {13'h0000, aug_in.geo_count}));
                        sum_clear    = 1'b1;
                        next_state   = gnss_msg_pkg::ST_START;
                    end else begin
                        next_refused = 1'b1;
                    end
                end
            end
            gnss_msg_pkg::ST_START: begin
                if (advance) begin
                    next_obyte  = gnss_msg_pkg::START_BYTE;
                    next_ovalid = 1'b1;
                    next_state  = gnss_msg_pkg::ST_TYPE;
                end
            end
            gnss_msg_pkg::ST_TYPE: begin
                if (advance) begin
                    next_obyte  = is_aug ? gnss_msg_pkg::TYPE_AUG
                                         : gnss_msg_pkg::TYPE_HEALTH;
                    next_ovalid = 1'b1;
                    sum_add     = 1'b1;
                    next_state  = gnss_msg_pkg::ST_LEN_HI;
                end
            end
            gnss_msg_pkg::ST_LEN_HI: begin
                if (advance) begin
                    next_obyte  = len[15:8];
                    next_ovalid = 1'b1;
                    sum_add     = 1'b1;
                    next_state  = gnss_msg_pkg::ST_LEN_LO;
                end
            end
            gnss_msg_pkg::ST_LEN_LO: begin
                if (advance) begin
                    next_obyte      = len[7:0];
                    next_ovalid     = 1'b1;
                    sum_add         = 1'b1;
                    next_off        = 6'h00;
                    next_rec        = 2'h0;
                    next_param_sent = !is_aug;
                    next_state      = gnss_msg_pkg::ST_PAYLOAD;
                end
            end
            gnss_msg_pkg::ST_PAYLOAD: begin
                if (advance) begin
                    next_ovalid = 1'b1;
                    sum_add     = 1'b1;
                    if (!is_aug) begin
                        // Subframe 4 field then subframe 5
                        next_obyte = hbits[HB_W - 1 - 8 * int'(off) -: 8];
                        next_off   = 6'(off + 6'h01);
                        if (off == gnss_msg_pkg::HEALTH_LAST) begin
                            next_state = gnss_msg_pkg::ST_CK_HI;
                        end
                    end else if (!param_sent) begin
                        // Counter, zero pair, GEO count code
                        next_obyte      = {counter,
                                           gnss_msg_pkg::ZERO2,
                                           geo_code(asnap.geo_count)};
                        next_param_sent = 1'b1;
                    end else begin
                        next_obyte = record_byte(asnap.rec[rec], off);
                        next_off   = 6'(off + 6'h01);
                        // Exactly geo_count records
                        if (off == gnss_msg_pkg::RECORD_LAST) begin
                            next_off = 6'h00;
                            next_rec = 2'(rec + 2'h1);
                            if ({1'b0, rec} == 3'(asnap.geo_count - 3'h1))
                            begin
                                next_state = gnss_msg_pkg::ST_CK_HI;
                            end
                        end
                    end
                end
            end
            gnss_msg_pkg::ST_CK_HI: begin
                // Sum already holds every byte from type to the payload's last
                if (advance) begin
                    next_obyte  = sum[15:8];
                    next_ovalid = 1'b1;
                    next_state  = gnss_msg_pkg::ST_CK_LO;
                end
            end
            gnss_msg_pkg::ST_CK_LO: begin
                if (advance) begin
                    next_obyte  = sum[7:0];
                    next_ovalid = 1'b1;
                    next_state  = gnss_msg_pkg::ST_END;
                end
            end
            gnss_msg_pkg::ST_END: begin
                if (advance) begin
                    next_obyte  = gnss_msg_pkg::END_BYTE;
                    next_ovalid = 1'b1;
                    next_state  = gnss_msg_pkg::ST_IDLE;
                end
            end
            default: begin
                // Illegal code: drop the frame and return to idle
                next_state = gnss_msg_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers only; the clock enable freezes everything
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state      <= gnss_msg_pkg::ST_IDLE;
            is_aug     <= 1'b0;
            off        <= 6'h00;
            rec        <= 2'h0;
            param_sent <= 1'b0;
            counter    <= 4'h0;
            len        <= 16'h0000;
            hsnap      <= '0;
            asnap      <= '0;
            obyte      <= 8'h00;
            ovalid     <= 1'b0;
            refused    <= 1'b0;
        end else if (ce_in) begin
            state      <= next_state;
            is_aug     <= next_is_aug;
            off        <= next_off;
            rec        <= next_rec;
            param_sent <= next_param_sent;
            counter    <= next_counter;
            len        <= next_len;
            hsnap      <= next_hsnap;
            asnap      <= next_asnap;
            obyte      <= next_obyte;
            ovalid     <= next_ovalid;
            refused    <= next_refused;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign byte_out        = obyte;
    assign byte_valid_out  = ovalid;
    assign busy_out        = (state != gnss_msg_pkg::ST_IDLE);
    assign req_refused_out = refused;
    assign msg_counter_out = counter;

endmodule

// file: verif/gnss_binary_msg_framer_chk.sv
// Checker for the binary message framer, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module gnss_binary_msg_framer_chk (
    // Clock and control
    input wire logic                      clk_in,
    input wire logic                      reset_n_in,
    input wire logic                      ce_in,
    // Requests
    input wire logic                      health_req_in,
    input wire gnss_msg_pkg::health_msg_s health_in,
    input wire logic                      aug_req_in,
    input wire gnss_msg_pkg::aug_msg_s    aug_in,
    // Stream and status
    input wire logic [7:0]                byte_out,
    input wire logic                      byte_valid_out,
    input wire logic                      byte_ready_in,
    input wire logic                      busy_out,
    input wire logic                      req_refused_out,
    input wire logic [3:0]                msg_counter_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    ////////////////////////////////////////////////////////////////////
    // Helper terms: a request that an idle framer must accept
    logic take_h; // Health frame accepted at this edge
    logic take_a; // Augmentation frame accepted at this edge
    assign take_h = !busy_out && ce_in && health_req_in
                    && health_in.sf4_valid && health_in.sf5_valid;
    assign take_a = !busy_out && ce_in && aug_req_in && !health_req_in
                    && aug_in.geo_count inside {[3'h1:3'h4]};

    // Frame opening: accepted request, then one enabled cycle
    sequence s_frame_open;
        (take_h || take_a) ##1 (ce_in && (!byte_valid_out || byte_ready_in));
    endsequence

    ////////////////////////////////////////////////////////////////////
    chk_open_busy: assert property ((take_h || take_a) |=> busy_out)
        else $error("busy not raised after accepted request");
    chk_start_byte: assert property (s_frame_open |=> byte_valid_out
        && byte_out == gnss_msg_pkg::START_BYTE)
        else $error("frame did not open with start byte");
    chk_end_byte: assert property (reset_n_in && $past(reset_n_in)
        && $fell(busy_out) |-> byte_valid_out
        && byte_out == gnss_msg_pkg::END_BYTE)
        else $error("frame did not close with end byte");
    chk_hold_byte: assert property (byte_valid_out && !byte_ready_in
        |=> byte_valid_out && $stable(byte_out))
        else $error("byte changed before it was taken");
    chk_count_step: assert property (take_a
        |=> msg_counter_out == $past(msg_counter_out) + 4'h1)
        else $error("counter did not step by one");
    chk_count_hold: assert property (!take_a |=> $stable(msg_counter_out))
        else $error("counter moved without a new message");
    chk_refuse_health: assert property (!busy_out && ce_in
        && health_req_in && !(health_in.sf4_valid && health_in.sf5_valid)
        |=> req_refused_out && !busy_out)
        else $error("health request on invalid data not refused");
    chk_refuse_geo: assert property (!busy_out && ce_in && aug_req_in
        && !health_req_in
        && !(aug_in.geo_count inside {[3'h1:3'h4]})
        |=> req_refused_out && !busy_out)
        else $error("bad GEO count not refused");
    chk_take_clean: assert property (take_h && !aug_req_in
        |=> !req_refused_out)
        else $error("valid health request refused");
endmodule

bind gnss_binary_msg_framer gnss_binary_msg_framer_chk
    gnss_binary_msg_framer_chk_inst (.clk_in, .reset_n_in, .ce_in,
    .health_req_in, .health_in, .aug_req_in, .aug_in, .byte_out,
    .byte_valid_out, .byte_ready_in, .busy_out, .req_refused_out,
    .msg_counter_out);

// file: verif/host_link_model.sv
// Host link model: takes framed bytes over a valid/ready handshake.
// Assumes the framer changes its outputs only just after rising edges.
`timescale 1ns/1ps
module host_link_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // Stream from the framer
    input  wire logic [7:0] byte_in,
    input  wire logic       valid_in,
    output logic            ready_out,
    // Pacing: high makes the host take one byte in three cycles
    input  wire logic       slow_in
);
    logic [7:0] got[$];  // Bytes taken, in arrival order
    logic [1:0] phase;   // Pacing counter for the slow mode

    ////////////////////////////////////////////////////////////////////
    // Take at the handshake edge, then move ready just after it
    always @(posedge clk_in) begin
        if (valid_in && ready_out) begin
            got.push_back(byte_in);
        end
        phase <= (!reset_n_in || phase == 2'h2) ? 2'h0 : phase + 2'h1;
        ready_out <= !slow_in || phase == 2'h1;
    end
    initial begin
        ready_out = 1'h0;
        phase = 2'h0;
    end
endmodule

// file: verif/gnss_binary_msg_framer_tb.sv
// Self-checking bench for the binary message framer.
// Assumes the host link model and the bound checker are compiled with it.
`timescale 1ns/1ps
module gnss_binary_msg_framer_tb;
    typedef struct {
        logic aug; logic [2:0] n; logic vld; logic [7:0] base;
        logic slow; logic gap; logic ref_exp; logic [15:0] len_exp;
    } row_s;
    logic                      clk_in = 1'h0;
    logic                      reset_n_in = 1'h0;
    logic                      ce_in = 1'h1;
    logic                      health_req_in = 1'h0;
    logic                      aug_req_in = 1'h0;
    gnss_msg_pkg::health_msg_s health_in = '0;
    gnss_msg_pkg::aug_msg_s    aug_in = '0;
    logic [7:0]                byte_out;
    logic                      byte_valid_out, byte_ready_in;
    logic                      busy_out, req_refused_out;
    logic [3:0]                msg_counter_out;
    logic                      slow_in = 1'h0; // Host pacing
    logic                      gap = 1'h0;     // Clock-enable gaps
    logic [3:0]                ctr = 4'h0;     // Expected counter
    logic [1:0]                cyc = 2'h0;
    int                        errors = 0;
    int                        checks = 0;
    row_s rows[8] = '{
        '{1'h0, 3'h0, 1'h1, 8'h11, 1'h0, 1'h0, 1'h0, 16'h0030},
        '{1'h1, 3'h1, 1'h1, 8'h22, 1'h0, 1'h0, 1'h0, 16'h001e},
        '{1'h1, 3'h2, 1'h1, 8'h33, 1'h1, 1'h0, 1'h0, 16'h003b},
        '{1'h1, 3'h3, 1'h1, 8'h44, 1'h0, 1'h1, 1'h0, 16'h0058},
        '{1'h1, 3'h4, 1'h1, 8'h55, 1'h1, 1'h1, 1'h0, 16'h0075},
        '{1'h0, 3'h0, 1'h0, 8'h66, 1'h0, 1'h0, 1'h1, 16'h0000},
        '{1'h1, 3'h0, 1'h1, 8'h77, 1'h0, 1'h0, 1'h1, 16'h0000},
        '{1'h1, 3'h5, 1'h1, 8'h88, 1'h0, 1'h0, 1'h1, 16'h0000}};

    ////////////////////////////////////////////////////////////////////
    // Design, host partner and clock
    gnss_binary_msg_framer gnss_binary_msg_framer_inst (.clk_in,
        .reset_n_in, .ce_in, .health_req_in, .health_in, .aug_req_in,
        .aug_in, .byte_out, .byte_valid_out, .byte_ready_in, .busy_out,
        .req_refused_out, .msg_counter_out);
    host_link_model host_link_model_inst (.clk_in, .reset_n_in,
        .byte_in(byte_out), .valid_in(byte_valid_out && ce_in),
        .ready_out(byte_ready_in), .slow_in);
    initial forever #10 clk_in = !clk_in;
    // Gaps in the enable only mid-frame, so requests are never lost
    always @(negedge clk_in) begin
        cyc <= cyc + 2'h1;
        ce_in <= !(gap && busy_out && cyc == 2'h3);
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [255:0] pat(input logic [7:0] s);
        for (int k = 0; k < 32; k++) pat[k*8 +: 8] = s + 8'(k) * 8'h1d;
    endfunction

    // One request, then the whole frame compared byte by byte
    task automatic run_row(input row_s r);
        gnss_msg_pkg::health_msg_s h;
        gnss_msg_pkg::aug_msg_s a;
        logic [7:0] pl[$], ex[$];
        logic [255:0] p;
        logic [383:0] hb;
        logic [15:0] sum, len;
        p = pat(r.base);
        h.sf4 = p[191:0];
        p = pat(~r.base);
        h.sf5 = p[191:0];
        h.sf4_valid = 1'h1;
        h.sf5_valid = r.vld;
        a.geo_count = r.n;
        for (int i = 0; i < 4; i++) begin
            p = pat(r.base + 8'(i));
            a.rec[i] = '{prn: r.base + 8'(i), crc_bad: i[0],
                msg_type: r.base[5:0] + 6'(i), preamble_id: 2'(i % 3 + 1),
                data: p[211:0]};
        end
        @(negedge clk_in);
        health_in = h;
        aug_in = a;
        health_req_in = !r.aug;
        aug_req_in = r.aug;
        slow_in = r.slow;
        gap = r.gap;
        host_link_model_inst.got.delete();
        @(negedge clk_in);
        health_req_in = 1'h0;
        aug_req_in = 1'h0;
        check("refused", 16'(req_refused_out), 16'(r.ref_exp));
        while (busy_out !== 1'h0) @(negedge clk_in);
        repeat (4) @(negedge clk_in);
        if (!r.ref_exp) begin
            if (r.aug) begin
                ctr++;
                pl.push_back({ctr, 2'h0, r.n[1:0]});
                for (int i = 0; i < r.n; i++) begin
                    pl.push_back(a.rec[i].prn);
                    pl.push_back({a.rec[i].crc_bad, 1'h0, a.rec[i].msg_type});
                    pl.push_back({a.rec[i].preamble_id, 2'h0,
                        a.rec[i].data[211:208]});
                    for (int k = 0; k < 26; k++)
                        pl.push_back(a.rec[i].data[207-8*k -: 8]);
                end
            end else begin
                hb = {h.sf4, h.sf5};
                for (int k = 0; k < 48; k++) pl.push_back(hb[383-8*k -: 8]);
            end
            len = 16'(pl.size());
            check("length", len, r.len_exp);
            ex = {gnss_msg_pkg::START_BYTE, r.aug ? gnss_msg_pkg::TYPE_AUG
                : gnss_msg_pkg::TYPE_HEALTH, len[15:8], len[7:0]};
            sum = 16'(ex[1]) + 16'(len[15:8]) + 16'(len[7:0]);
            foreach (pl[k]) sum += 16'(pl[k]);
            ex = {ex, pl, sum[15:8], sum[7:0], gnss_msg_pkg::END_BYTE};
        end
        check("frame size", 16'(host_link_model_inst.got.size()), 16'(ex.size()));
        foreach (ex[k]) if (k < host_link_model_inst.got.size())
            check("frame byte", 16'(host_link_model_inst.got[k]), 16'(ex[k]));
        check("counter", 16'(msg_counter_out), 16'(ctr));
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence: table rows, counter wrap, then reset mid-frame
    initial begin
        repeat (3) @(negedge clk_in);
        reset_n_in = 1'h1;
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Twelve more frames carry the counter through its wrap to zero
        for (int j = 0; j < 12; j++)
            run_row('{1'h1, 3'h1, 1'h1, 8'(j), 1'h0, 1'h0, 1'h0, 16'h001e});
        $display("wrap test done");
        @(negedge clk_in);
        aug_in.geo_count = 3'h4;
        aug_req_in = 1'h1;
        @(negedge clk_in);
        aug_req_in = 1'h0;
        repeat (20) @(negedge clk_in);
        reset_n_in = 1'h0;
        repeat (3) @(negedge clk_in);
        check("rst valid", 16'(byte_valid_out), 16'h0000);
        check("rst busy", 16'(busy_out), 16'h0000);
        check("rst counter", 16'(msg_counter_out), 16'h0000);
        reset_n_in = 1'h1;
        ctr = 4'h0;
        run_row(rows[0]);
        run_row(rows[1]);
        $display("reset test done");
        print_verdict();
    end
    // Watchdog: the whole run needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        print_verdict();
    end
endmodule
